//--- adcct_pkg.sv
// Function
// - Conversion ends within mode's conversion time.
// - Busy bounded by conversion time, most readout modes.
// - Parallel data valid 20 ns before busy falls.
// - Parallel data driven soon after bus request.
// - Shift clock period not below divider minimum.
// - Shift clock period not above divider maximum for dividers 2 and 3; 100 ns for dividers 0 and 1.
// - Read-after-convert busy bounded per divider and mode.
// - Frame sync rises after conversion time in read-after-convert; at conversion start in read-during.
// - Busy falls shortly after frame sync falls, in read-after-convert mode.
// - Gap from last shift edge to sync change.
// - Gap from sync rise to first shift edge.
// - Chip select high releases serial outputs.
// - Result readable at once; read-during readout sends the previous result.
`default_nettype none

package adcct_pkg;
	localparam int CLK_NS = 50;
	localparam int RES_W = 18;
	localparam int CNT_W = 6;
	localparam int ADDR_W = 8;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;

	localparam int CTRL_SPEED_LSB = 0;
	localparam int CTRL_READ_LSB = 2;
	localparam int CTRL_DIV_LSB = 4;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NEW = 1;
	localparam int STAT_SHIFT = 2;

	localparam logic [1:0] SPEED_FAST = 2'h0;
	localparam logic [1:0] SPEED_NORMAL = 2'h1;
	localparam logic [1:0] SPEED_LOWPWR = 2'h2;
	localparam logic [1:0] RD_PARALLEL = 2'h0;
	localparam logic [1:0] RD_AFTER = 2'h1;
	localparam logic [1:0] RD_DURING = 2'h2;
	localparam logic [1:0] RD_SLAVE = 2'h3;
	localparam logic [1:0] DIV_FASTEST = 2'h0;

	localparam int CONV_FAST_NS = 1000;
	localparam int CONV_NORMAL_NS = 1250;
	localparam int CONV_LOWPWR_NS = 1500;
	localparam int DATA_LEAD_NS = 20;
	localparam int SCLK_MAX_NS [4] = '{40, 80, 160, 320};
	localparam int FIRST_EDGE_NS [4] = '{3, 17, 17, 17};
	localparam int LAST_EDGE_NS [4] = '{3, 60, 140, 300};

	// Longest times round down, least times round up, never below one cycle.
	function automatic logic [CNT_W-1:0] cyc_dn(input int ns);
		int c;
		c = ns / CLK_NS;
		return (c < 1) ? CNT_W'(1) : CNT_W'(c);
	endfunction : cyc_dn

	function automatic logic [CNT_W-1:0] cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? CNT_W'(1) : CNT_W'(c);
	endfunction : cyc_up

	localparam logic [CNT_W-1:0] DATA_LEAD_CYC = cyc_up(DATA_LEAD_NS);
	localparam logic [CNT_W-1:0] RESULT_LOAD_AT = CNT_W'(DATA_LEAD_CYC + 1);

	function automatic logic [CNT_W-1:0] conv_cycles(input logic [1:0] speed);
		logic [CNT_W-1:0] c;
		case (speed)
			SPEED_FAST: c = cyc_dn(CONV_FAST_NS);
			SPEED_NORMAL: c = cyc_dn(CONV_NORMAL_NS);
			default: c = cyc_dn(CONV_LOWPWR_NS);
		endcase
		return c;
	endfunction : conv_cycles

	function automatic logic [CNT_W-1:0] half_cycles(input logic [1:0] div);
		return cyc_dn(SCLK_MAX_NS[div] / 2);
	endfunction : half_cycles

	function automatic logic [CNT_W-1:0] first_cycles(input logic [1:0] div);
		return cyc_up(FIRST_EDGE_NS[div]);
	endfunction : first_cycles

	function automatic logic [CNT_W-1:0] gap_cycles(input logic [1:0] div);
		return cyc_up(LAST_EDGE_NS[div]);
	endfunction : gap_cycles
endpackage : adcct_pkg

`default_nettype wire

//--- adcct_conv_timer.sv
`default_nettype none

module adcct_conv_timer #(
	parameter int CW = 6
) (
	input wire logic clk, // Block clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic start, // Loads the count.
	input wire logic [CW-1:0] load, // Cycles the conversion takes.
	output logic [CW-1:0] count, // Cycles left.
	output logic done // High in the last cycle of the count.
);
	logic [CW-1:0] next_count;

	if (CW < 2) begin : g_chk
		$error("adcct_conv_timer: CW must be at least 2");
	end

	assign done = (count == CW'(1));

	always_comb begin
		next_count = count;
		if (start) begin
			next_count = load;
		end else if (count != '0) begin
			next_count = count - CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule : adcct_conv_timer

`default_nettype wire

//--- adcct_shifter.sv
`default_nettype none

module adcct_shifter #(
	parameter int W = 18
) (
	input wire logic clk, // Block clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic start, // Begins a transfer of word.
	input wire logic slave, // Transfer clocked by the host.
	input wire logic [W-1:0] word, // Value to send, MSB first.
	input wire logic [1:0] div, // Shift clock divider select.
	input wire logic ext_fall, // Falling edge of the host shift clock.
	output logic sclk, // Generated shift clock.
	output logic sync, // Frame sync.
	output logic sdo, // Serial data.
	output logic done, // One-cycle pulse at transfer end.
	output logic active // Transfer in progress.
);
	localparam int BW = $clog2(W);
	localparam int CW = adcct_pkg::CNT_W;

	typedef enum logic [2:0] {SH_IDLE, SH_LEAD, SH_HIGH, SH_LOW, SH_TAIL, SH_SLAVE} adcct_sh_state_t;

	adcct_sh_state_t state, next_state;
	logic [CW-1:0] cnt, next_cnt;
	logic [BW-1:0] bits, next_bits;
	logic [W-1:0] shreg, next_shreg;
	logic [1:0] sel_div, next_sel_div;
	logic next_sclk, next_sync, next_sdo, next_done;

	if (W < 2 || W > 32) begin : g_chk
		$error("adcct_shifter: W must be 2 to 32");
	end

	assign active = (state != SH_IDLE);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_bits = bits;
		next_shreg = shreg;
		next_sel_div = sel_div;
		next_sclk = sclk;
		next_sync = sync;
		next_sdo = sdo;
		next_done = 1'b0;
		if (start) begin
			next_shreg = word;
			next_sel_div = div;
			next_bits = '0;
			next_sdo = word[W-1];
			next_sclk = 1'b0;
			next_sync = !slave;
			next_cnt = adcct_pkg::first_cycles(div);
			next_state = slave ? SH_SLAVE : SH_LEAD;
		end else begin
			unique case (state)
				SH_IDLE: begin
				end
				SH_LEAD: begin
					next_cnt = cnt - CW'(1);
					if (cnt == CW'(1)) begin
						next_sclk = 1'b1;
						next_cnt = adcct_pkg::half_cycles(sel_div);
						next_state = SH_HIGH;
					end
				end
				SH_HIGH: begin
					next_cnt = cnt - CW'(1);
					if (cnt == CW'(1)) begin
						next_sclk = 1'b0;
						next_bits = bits + BW'(1);
						if (bits == BW'(W - 1)) begin
							next_cnt = adcct_pkg::gap_cycles(sel_div);
							next_state = SH_TAIL;
						end else begin
							next_shreg = {shreg[W-2:0], 1'b0};
							next_sdo = shreg[W-2];
							next_cnt = adcct_pkg::half_cycles(sel_div);
							next_state = SH_LOW;
						end
					end
				end
				SH_LOW: begin
					next_cnt = cnt - CW'(1);
					if (cnt == CW'(1)) begin
						next_sclk = 1'b1;
						next_cnt = adcct_pkg::half_cycles(sel_div);
						next_state = SH_HIGH;
					end
				end
				SH_TAIL: begin
					next_cnt = cnt - CW'(1);
					if (cnt == CW'(1)) begin
						next_sync = 1'b0;
						next_done = 1'b1;
						next_state = SH_IDLE;
					end
				end
				SH_SLAVE: begin
					if (ext_fall) begin
						next_bits = bits + BW'(1);
						next_shreg = {shreg[W-2:0], 1'b0};
						next_sdo = shreg[W-2];
						if (bits == BW'(W - 1)) begin
							next_done = 1'b1;
							next_state = SH_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SH_IDLE;
			cnt <= '0;
			bits <= '0;
			shreg <= '0;
			sel_div <= 2'h0;
			sclk <= 1'b0;
			sync <= 1'b0;
			sdo <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bits <= next_bits;
			shreg <= next_shreg;
			sel_div <= next_sel_div;
			sclk <= next_sclk;
			sync <= next_sync;
			sdo <= next_sdo;
			done <= next_done;
		end
	end
endmodule : adcct_shifter

`default_nettype wire

//--- adcct_top.sv
`default_nettype none

module adcct_top #(
	parameter int RES_W = adcct_pkg::RES_W
) (
	input wire logic pclk, // Block clock, 20 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [adcct_pkg::ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic conversion_start_n, // Conversion start pin, falling edge starts.
	input wire logic cs_n, // Chip select pin, active low.
	input wire logic rd_n, // Parallel bus access request, active low.
	input wire logic sclk_in, // Shift clock pin level, host clock in slave mode.
	input wire logic [RES_W-1:0] sample_in, // Value the conversion resolves to.
	output logic busy, // Conversion in progress.
	output logic [RES_W-1:0] par_data, // Parallel result.
	output logic par_data_oe, // Drive enable of par_data.
	output logic serial_result_out, // Serial result.
	output logic serial_result_out_oe, // Drive enable of serial_result_out.
	output logic sync_out, // Frame sync.
	output logic sync_out_oe, // Drive enable of sync_out.
	output logic sclk_out, // Generated shift clock.
	output logic sclk_out_oe // Drive enable of sclk_out.
);
	localparam int CW = adcct_pkg::CNT_W;
	localparam int CL = adcct_pkg::CTRL_W;

	typedef enum logic [1:0] {CV_IDLE, CV_CONVERT, CV_READOUT} adcct_cv_state_t;

	if (RES_W < 2 || RES_W > 32) begin : g_chk
		$error("adcct_top: RES_W must be 2 to 32");
	end

	// Pin synchronisers; bit order is sclk_in, rd_n, cs_n, conversion_start_n.
	logic [3:0] pin_meta, pin_sync;
	logic conversion_start_n_last, sclk_last;
	logic [RES_W-1:0] sample_meta, sample_sync;
	logic start_edge, sclk_fall, cs_act, rd_act;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 4'h7;
			pin_sync <= 4'h7;
			conversion_start_n_last <= 1'b1;
			sclk_last <= 1'b0;
			sample_meta <= '0;
			sample_sync <= '0;
		end else begin
			pin_meta <= {sclk_in, rd_n, cs_n, conversion_start_n};
			pin_sync <= pin_meta;
			conversion_start_n_last <= pin_sync[0];
			sclk_last <= pin_sync[3];
			sample_meta <= sample_in;
			sample_sync <= sample_meta;
		end
	end

	assign start_edge = conversion_start_n_last && !pin_sync[0];
	assign sclk_fall = sclk_last && !pin_sync[3];
	assign cs_act = !pin_sync[1];
	assign rd_act = !pin_sync[2];

	// Register file.
	logic [CL-1:0] ctrl, next_ctrl;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic result_new, next_new;
	logic rd_result;
	logic [RES_W-1:0] result, next_result;
	logic [1:0] ctrl_speed, ctrl_read, ctrl_div;

	assign ctrl_speed = ctrl[adcct_pkg::CTRL_SPEED_LSB +: 2];
	assign ctrl_read = ctrl[adcct_pkg::CTRL_READ_LSB +: 2];
	assign ctrl_div = ctrl[adcct_pkg::CTRL_DIV_LSB +: 2];
	assign rd_result = psel && penable && pready && !pwrite && paddr == adcct_pkg::OFS_RESULT;

	// Shifter and timer hookup.
	logic tm_start, tm_done;
	logic [CW-1:0] tm_count;
	logic sh_start, sh_slave, sh_done, sh_active;
	logic [RES_W-1:0] sh_word;
	logic [1:0] sh_div;

	always_comb begin
		next_ctrl = ctrl;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (psel && !penable) begin
			next_pready = 1'b1;
			case (paddr)
				adcct_pkg::OFS_CTRL: next_prdata = {{(32 - CL){1'b0}}, ctrl};
				adcct_pkg::OFS_STATUS: begin
					next_prdata = 32'h0000_0000;
					next_prdata[adcct_pkg::STAT_BUSY] = busy;
					next_prdata[adcct_pkg::STAT_NEW] = result_new;
					next_prdata[adcct_pkg::STAT_SHIFT] = sh_active;
				end
				adcct_pkg::OFS_RESULT: next_prdata = {{(32 - RES_W){1'b0}}, result};
				default: begin
					next_prdata = 32'h0000_0000;
					next_pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && pready && pwrite && paddr == adcct_pkg::OFS_CTRL) begin
			next_ctrl = pwdata[CL-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= adcct_pkg::CTRL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Conversion sequencer.
	adcct_cv_state_t state, next_state;
	logic next_busy;
	logic [RES_W-1:0] capture, next_capture;
	logic [1:0] cfg_read, next_read, cfg_div, next_div;

	always_comb begin
		next_state = state;
		next_busy = busy;
		next_result = result;
		next_capture = capture;
		next_read = cfg_read;
		next_div = cfg_div;
		next_new = result_new;
		tm_start = 1'b0;
		sh_start = 1'b0;
		sh_slave = 1'b0;
		sh_word = result;
		sh_div = cfg_div;
		if (rd_result) begin
			next_new = 1'b0;
		end
		unique case (state)
			CV_IDLE: begin
				// Starts while a conversion or a read-after-convert readout runs are ignored.
				if (start_edge) begin
					next_state = CV_CONVERT;
					next_busy = 1'b1;
					next_capture = sample_sync;
					next_read = ctrl_read;
					next_div = ctrl_div;
					tm_start = 1'b1;
					if (ctrl_read == adcct_pkg::RD_DURING) begin
						sh_start = 1'b1;
						sh_div = adcct_pkg::DIV_FASTEST;
					end
				end
			end
			CV_CONVERT: begin
				if (tm_count == adcct_pkg::RESULT_LOAD_AT) begin
					next_result = capture;
					next_new = 1'b1;
				end
				if (tm_done) begin
					if (cfg_read == adcct_pkg::RD_AFTER) begin
						sh_start = 1'b1;
						next_state = CV_READOUT;
					end else begin
						next_busy = 1'b0;
						next_state = CV_IDLE;
						if (cfg_read == adcct_pkg::RD_SLAVE) begin
							sh_start = 1'b1;
							sh_slave = 1'b1;
						end
					end
				end
			end
			CV_READOUT: begin
				if (sh_done) begin
					next_busy = 1'b0;
					next_state = CV_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CV_IDLE;
			busy <= 1'b0;
			result <= '0;
			capture <= '0;
			cfg_read <= adcct_pkg::RD_PARALLEL;
			cfg_div <= 2'h0;
			result_new <= 1'b0;
		end else begin
			state <= next_state;
			busy <= next_busy;
			result <= next_result;
			capture <= next_capture;
			cfg_read <= next_read;
			cfg_div <= next_div;
			result_new <= next_new;
		end
	end

	assign par_data = result;

	// Pin drive enables follow chip select and the readout mode.
	logic next_par_oe, next_sdo_oe, next_master_oe, master_oe;

	always_comb begin
		next_par_oe = cs_act && rd_act && ctrl_read == adcct_pkg::RD_PARALLEL;
		next_sdo_oe = cs_act && ctrl_read != adcct_pkg::RD_PARALLEL;
		next_master_oe = cs_act && (ctrl_read == adcct_pkg::RD_AFTER || ctrl_read == adcct_pkg::RD_DURING);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_data_oe <= 1'b0;
			serial_result_out_oe <= 1'b0;
			master_oe <= 1'b0;
		end else begin
			par_data_oe <= next_par_oe;
			serial_result_out_oe <= next_sdo_oe;
			master_oe <= next_master_oe;
		end
	end

	assign sync_out_oe = master_oe;
	assign sclk_out_oe = master_oe;

	adcct_conv_timer #(
		.CW(CW)
	) u_timer (
		.clk(pclk),
		.rst_n(presetn),
		.start(tm_start),
		.load(adcct_pkg::conv_cycles(ctrl_speed)),
		.count(tm_count),
		.done(tm_done)
	);

	adcct_shifter #(
		.W(RES_W)
	) u_shifter (
		.clk(pclk),
		.rst_n(presetn),
		.start(sh_start),
		.slave(sh_slave),
		.word(sh_word),
		.div(sh_div),
		.ext_fall(sclk_fall),
		.sclk(sclk_out),
		.sync(sync_out),
		.sdo(serial_result_out),
		.done(sh_done),
		.active(sh_active)
	);
endmodule : adcct_top

`default_nettype wire

//--- adcct_monitor.sv
`default_nettype none

module adcct_chk #(
	parameter int RES_W = 18
) (
	input wire logic pclk, // Block clock.
	input wire logic presetn, // Reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [adcct_pkg::ADDR_W-1:0] paddr, // APB address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic pready, // APB ready.
	input wire logic cs_n, // Chip select.
	input wire logic busy, // Conversion busy.
	input wire logic [RES_W-1:0] par_data, // Parallel result.
	input wire logic serial_result_out_oe, // Serial data enable.
	input wire logic sync_out, // Frame sync.
	input wire logic sync_out_oe, // Frame sync enable.
	input wire logic sclk_out, // Shift clock.
	input wire logic sclk_out_oe // Shift clock enable.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] speed;
	logic [1:0] rd;
	logic [1:0] div;
	logic [7:0] bcnt;
	logic [7:0] hcnt;
	logic sclk_q;
	int lim;
	int half;
	int gap;
	always_comb begin
		lim = (1000 + 250 * ((speed == 2'h3) ? 2 : int'(speed))) / 50;
		half = (rd == adcct_pkg::RD_AFTER && div == 2'h3) ? 3 : 1;
		gap = (rd == adcct_pkg::RD_AFTER) ? (adcct_pkg::LAST_EDGE_NS[div] + 49) / 50 : 1;
	end
	// The mode fields are mirrored from CTRL writes; hcnt counts cycles since the shift clock last moved.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed <= 2'h0;
			rd <= 2'h0;
			div <= 2'h0;
			bcnt <= 8'h00;
			hcnt <= 8'h00;
			sclk_q <= 1'b0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == adcct_pkg::OFS_CTRL) begin
				speed <= pwdata[1:0];
				rd <= pwdata[3:2];
				div <= pwdata[5:4];
			end
			bcnt <= busy ? bcnt + 8'h01 : 8'h00;
			hcnt <= (sclk_out != sclk_q) ? 8'h01 : hcnt + 8'h01;
			sclk_q <= sclk_out;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_conv_time: assert property ($fell(busy) && rd != adcct_pkg::RD_AFTER |-> bcnt == lim)
		else $error("busy width differs from conversion time");
	a_busy_max: assert property (busy && rd != adcct_pkg::RD_AFTER |-> bcnt < lim)
		else $error("busy high too long");
	a_data_lead: assert property ($fell(busy) |-> $stable(par_data))
		else $error("result changed as busy fell");
	a_sclk_high: assert property ($fell(sclk_out) |-> hcnt == half)
		else $error("shift clock high phase wrong");
	a_sync_start: assert property ($rose(sync_out) && rd == adcct_pkg::RD_AFTER |-> bcnt == lim)
		else $error("frame sync late or early");
	a_busy_after: assert property ($fell(sync_out) && rd == adcct_pkg::RD_AFTER |=> $fell(busy))
		else $error("busy did not fall after frame sync");
	a_end_gap: assert property ($fell(sync_out) && rd != adcct_pkg::RD_SLAVE |-> hcnt == gap)
		else $error("gap before frame sync end wrong");
	a_first_edge: assert property ($rose(sync_out) && rd != adcct_pkg::RD_SLAVE |-> !sclk_out ##1 $rose(sclk_out))
		else $error("first shift edge not one cycle after sync");
	a_cs_release: assert property (cs_n [*5] |-> !serial_result_out_oe && !sync_out_oe && !sclk_out_oe)
		else $error("serial outputs still driven");
endmodule : adcct_chk

bind adcct_top adcct_chk #(.RES_W(RES_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .cs_n, .busy, .par_data, .serial_result_out_oe, .sync_out, .sync_out_oe, .sclk_out, .sclk_out_oe);

`default_nettype wire

//--- adcct_host.sv
`default_nettype none

module adcct_host (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	input wire logic go, // Asks for a conversion start.
	input wire logic eager, // Skips the spacing wait.
	input wire logic [1:0] speed, // Throughput mode in use.
	input wire logic sync_out, // Frame sync.
	input wire logic sclk_out, // Shift clock.
	input wire logic serial_result_out, // Serial data.
	input wire logic busy, // Conversion busy.
	input wire logic slave, // Host clocks the readout.
	output logic host_sclk, // Host shift clock, idles high.
	output logic conversion_start_n, // Start pin.
	output logic [adcct_pkg::RES_W-1:0] word, // Last word received.
	output logic [7:0] words // Words received.
);
	timeunit 1ns;
	timeprecision 1ns;
	int space;
	int gapc;
	int low;
	logic sq;
	logic cq;
	logic bq;
	logic [3:0] sph;
	int sbits;
	logic [adcct_pkg::RES_W-1:0] sh;
	// Starts keep the least spacing of the mode unless eager is high, and runs stay far below 1 ms in fast mode.
	assign space = 25 + 5 * ((speed == 2'h3) ? 2 : int'(speed));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_start_n <= 1'b1;
			gapc <= 0;
			low <= 0;
			sq <= 1'b0;
			cq <= 1'b0;
			bq <= 1'b0;
			sph <= 4'h0;
			sbits <= 0;
			host_sclk <= 1'b1;
			sh <= '0;
			word <= '0;
			words <= 8'h00;
		end else begin
			sq <= sclk_out;
			cq <= sync_out;
			bq <= busy;
			gapc <= gapc + 1;
			// In slave readout each bit is taken just before the clock falls; 16-cycle period.
			if (slave && bq && !busy) begin
				sbits <= adcct_pkg::RES_W;
				sph <= 4'h0;
			end else if (sbits != 0 || sph != 4'h0) begin
				sph <= sph + 4'h1;
				if (sph == 4'h7 && sbits != 0) begin
					host_sclk <= 1'b0;
					sh <= {sh[adcct_pkg::RES_W-2:0], serial_result_out};
					sbits <= sbits - 1;
					if (sbits == 1) begin
						word <= {sh[adcct_pkg::RES_W-2:0], serial_result_out};
						words <= words + 8'h01;
					end
				end
				if (sph == 4'hF)
					host_sclk <= 1'b1;
			end
			if (low != 0) begin
				low <= low - 1;
				conversion_start_n <= (low == 1);
			end else if (go && (eager || gapc >= space)) begin
				conversion_start_n <= 1'b0;
				low <= 3;
				gapc <= 0;
			end
			if (sync_out && sclk_out && !sq)
				sh <= {sh[adcct_pkg::RES_W-2:0], serial_result_out};
			if (cq && !sync_out) begin
				word <= sh;
				words <= words + 8'h01;
			end
		end
	end
endmodule : adcct_host

`default_nettype wire

//--- adc_conversion_readout_timing_test.sv
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin errors++; $display("[ERR] %0t mismatch got %h exp %h", $time, g, x); end end

module adc_conversion_readout_timing_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, busy, par_data_oe, sro, sro_oe, sync_out, sync_oe, sclk_out, sclk_oe, start_n;
	logic cs_n = 1'b1, rd_n = 1'b1, go = 1'b0, eager = 1'b0, hslave = 1'b0, sclk_h;
	logic [1:0] hspeed = 2'h0;
	logic [17:0] sample_in = 18'h0, par_data, word;
	logic [7:0] words;
	logic [17:0] res_q[$];
	int errors = 0, num_checks = 0, seed = 75;
	int conv_ns[3] = '{1000, 1250, 1500};

	always #25 pclk = ~pclk;

	adcct_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.conversion_start_n(start_n), .cs_n, .rd_n, .sclk_in(sclk_h), .sample_in, .busy, .par_data, .par_data_oe,
		.serial_result_out(sro), .serial_result_out_oe(sro_oe), .sync_out, .sync_out_oe(sync_oe), .sclk_out,
		.sclk_out_oe(sclk_oe));
	adcct_host HOST (.pclk, .presetn, .go, .eager, .speed(hspeed), .sync_out, .sclk_out,
		.serial_result_out(sro), .busy, .slave(hslave), .host_sclk(sclk_h), .conversion_start_n(start_n), .word,
		.words);

	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One conversion; dup makes the host start again while busy, which must be ignored.
	task automatic conv(input int sp, input int rdm, input int dv, input bit dup);
		int n;
		int w;
		logic [7:0] k;
		logic [17:0] s;
		logic [17:0] p;
		s = 18'($random(seed));
		p = (res_q.size() > 0) ? res_q[$] : 18'h0;
		apb(1'b1, adcct_pkg::OFS_CTRL, 32'(sp + 4 * rdm + 16 * dv));
		k = words;
		sample_in <= s;
		hspeed <= 2'(sp);
		hslave <= (rdm == 3);
		go <= 1'b1;
		n = 0;
		while (busy !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		go <= dup;
		eager <= dup;
		w = 0;
		while (busy === 1'b1 && w < 400) begin
			@(posedge pclk);
			w++;
			if (w == 6) begin
				go <= 1'b0;
				eager <= 1'b0;
			end
		end
		res_q.push_back(s);
		if (rdm != 1) `CHK(w, conv_ns[sp] / 50)
		`CHK(par_data, s)
		apb(1'b0, adcct_pkg::OFS_STATUS, 32'h0);
		`CHK(q[1:0], 2'b10)
		apb(1'b0, adcct_pkg::OFS_RESULT, 32'h0);
		`CHK(q, 32'(s))
		if (rdm != 0) begin
			n = 0;
			while (words === k && n < 400) begin
				@(posedge pclk);
				n++;
			end
			`CHK(word, (rdm == 2) ? p : s)
		end
	endtask : conv

	initial begin
		#1_000_000;
		errors++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, adcct_pkg::OFS_CTRL, 32'h0);
		`CHK(q, 32'h0)
		apb(1'b0, adcct_pkg::OFS_STATUS, 32'h0);
		`CHK(q, 32'h0)
		apb(1'b1, adcct_pkg::OFS_CTRL, 32'hFFFF_FFFF);
		apb(1'b0, adcct_pkg::OFS_CTRL, 32'h0);
		`CHK(q, 32'h3F)
		apb(1'b1, adcct_pkg::OFS_RESULT, 32'h5);
		`CHK(e, 1'b0)
		apb(1'b0, 8'h0C, 32'h0);
		`CHK({e, q}, 33'h1_0000_0000)
		$display("test registers done");
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		for (int i = 0; i < 3; i++)
			conv(i, 0, 0, i == 1);
		`CHK(par_data_oe, 1'b1)
		$display("test parallel done");
		for (int i = 0; i < 4; i++)
			conv(0, 1, i, 0);
		conv(2, 1, 3, 0);
		$display("test read after done");
		conv(1, 2, 0, 0);
		conv(1, 2, 0, 0);
		$display("test read during done");
		conv(0, 3, 0, 0);
		conv(2, 3, 0, 0);
		$display("test slave done");
		for (int i = 0; i < 6; i++)
			conv({$random(seed)} % 3, {$random(seed)} % 4, {$random(seed)} % 4, 0);
		$display("test random done");
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (6) @(posedge pclk);
		`CHK({sro_oe, sync_oe, sclk_oe, par_data_oe}, 4'h0)
		$display("test release done");
		wrap_up();
	end
endmodule : adc_conversion_readout_timing_test

`default_nettype wire
